// *** src/drive_alarm_status_regs.vh ***
// Constants for the drive alarm and monitor register bank.
`ifndef DRIVE_ALARM_STATUS_REGS_VH
`define DRIVE_ALARM_STATUS_REGS_VH

// ----------------------------------------
// Word addresses
// ----------------------------------------
`define ADDR_FIRMWARE_VERSION 16'h0000
`define ADDR_ACTIVE_ALARM_CODE 16'h0002
`define ADDR_PANEL_MONITOR_SELECT 16'h0004

// ----------------------------------------
// Reset values and the version word
// ----------------------------------------
// Version value is arbitrary.
`define FIRMWARE_VERSION_VALUE 16'h0064
`define ALARM_NONE 16'h0000
`define MONITOR_SELECT_RESET 16'h0000
`define ALARM_CLEAR_VALUE 16'h0000

// ----------------------------------------
// Monitor selection range
// ----------------------------------------
`define MONITOR_SELECT_MIN 16'h0000
`define MONITOR_SELECT_MAX 16'h006f
`define MONITOR_SELECT_NEG 16'hff90

// ----------------------------------------
// Parameter attribute flags and settings
// ----------------------------------------
`define SELECT_LOCKED_SERVO_ON 1'b0
`define SELECT_POWER_CYCLE 1'b0
`define UV_ONLY_SERVO_ON 1'b1

// ----------------------------------------
// Fault event vector positions and codes
// ----------------------------------------
`define FAULT_COUNT 28
`define FAULT_UNDER_VOLTAGE_BIT 2
`define CODE_OVER_CURRENT 16'h0001
`define CODE_OVER_VOLTAGE 16'h0002
`define CODE_UNDER_VOLTAGE 16'h0003
`define CODE_MOTOR_MISMATCH 16'h0004
`define CODE_REGEN_ERROR 16'h0005
`define CODE_OVERLOAD 16'h0006
`define CODE_OVER_SPEED 16'h0007
`define CODE_PULSE_COMMAND 16'h0008
`define CODE_POSITION_DEVIATION 16'h0009
`define CODE_ENCODER_LINK 16'h0011
`define CODE_ADJUSTMENT 16'h0012
`define CODE_EMERGENCY_STOP 16'h0013
`define CODE_REVERSE_LIMIT 16'h0014
`define CODE_FORWARD_LIMIT 16'h0015
`define CODE_IGBT_OVERHEAT 16'h0016
`define CODE_NVM_FAULT 16'h0017
`define CODE_SIGNAL_OUTPUT 16'h0018
`define CODE_SERIAL_ERROR 16'h0019
`define CODE_SERIAL_TIMEOUT 16'h0020
`define CODE_PHASE_LOSS 16'h0022
`define CODE_OVERLOAD_WARNING 16'h0023
`define CODE_ENC_MAGNETIC 16'h0024
`define CODE_ENC_INTERNAL_A 16'h0025
`define CODE_ENC_DATA 16'h0026
`define CODE_ENC_INTERNAL_B 16'h0027
`define CODE_MOTOR_CRASH 16'h0030
`define CODE_POWER_MISWIRE 16'h0031
`define CODE_FW_UPGRADE 16'h0099

`endif

// *** src/pin_sync3.v ***
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
   input wire sys_clk,
   input wire rst_b,
   input wire pin_in,
   output reg level_q
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   // ----------------------------------------
   // Chain and filter
   // ----------------------------------------
   // The first stage feeds only the second; the filter looks at stages two and three.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

endmodule // pin_sync3

`default_nettype wire

// *** src/alarm_code_encoder.v ***
// Priority encoder from fault events to BCD alarm codes.
`timescale 1ns/1ps
`default_nettype none
`include "drive_alarm_status_regs.vh"

module alarm_code_encoder (
   input wire [`FAULT_COUNT-1:0] fault_vec,
   output reg [15:0] code,
   output reg any_fault
);

   integer i;

   // Codes 010 and 021 have no event position, so they can never appear.
   function [15:0] code_of;
      input [4:0] idx;
      begin
         case (idx)
            5'd0: code_of = `CODE_OVER_CURRENT;
            5'd1: code_of = `CODE_OVER_VOLTAGE;
            5'd2: code_of = `CODE_UNDER_VOLTAGE;
            5'd3: code_of = `CODE_MOTOR_MISMATCH;
            5'd4: code_of = `CODE_REGEN_ERROR;
            5'd5: code_of = `CODE_OVERLOAD;
            5'd6: code_of = `CODE_OVER_SPEED;
            5'd7: code_of = `CODE_PULSE_COMMAND;
            5'd8: code_of = `CODE_POSITION_DEVIATION;
            5'd9: code_of = `CODE_ENCODER_LINK;
            5'd10: code_of = `CODE_ADJUSTMENT;
            5'd11: code_of = `CODE_EMERGENCY_STOP;
            5'd12: code_of = `CODE_REVERSE_LIMIT;
            5'd13: code_of = `CODE_FORWARD_LIMIT;
            5'd14: code_of = `CODE_IGBT_OVERHEAT;
            5'd15: code_of = `CODE_NVM_FAULT;
            5'd16: code_of = `CODE_SIGNAL_OUTPUT;
            5'd17: code_of = `CODE_SERIAL_ERROR;
            5'd18: code_of = `CODE_SERIAL_TIMEOUT;
            5'd19: code_of = `CODE_PHASE_LOSS;
            5'd20: code_of = `CODE_OVERLOAD_WARNING;
            5'd21: code_of = `CODE_ENC_MAGNETIC;
            5'd22: code_of = `CODE_ENC_INTERNAL_A;
            5'd23: code_of = `CODE_ENC_DATA;
            5'd24: code_of = `CODE_ENC_INTERNAL_B;
            5'd25: code_of = `CODE_MOTOR_CRASH;
            5'd26: code_of = `CODE_POWER_MISWIRE;
            5'd27: code_of = `CODE_FW_UPGRADE;
            default: code_of = `ALARM_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Lowest position wins
   // ----------------------------------------
   // Scanning downward lets the lowest set position overwrite the others.
   always @* begin
      code = `ALARM_NONE;
      any_fault = 1'b0;
      for (i = `FAULT_COUNT - 1; i >= 0; i = i - 1) begin
         if (fault_vec[i]) begin
            code = code_of(i[4:0]);
            any_fault = 1'b1;
         end
      end
   end

endmodule // alarm_code_encoder

`default_nettype wire

// *** src/drive_alarm_status_regs.v ***
// Monitor register bank of the servo drive: version, alarm code and panel selector.
// Integration notes
// rst_b stands for the drive's power cycle; por_b clears only the staged
// selector copy and is meant for the very first power-up.
// The first request may come at the second edge after rst_b rises; the
// first edge reloads the selector from its staged copy and would win.
// Only one of reg_wr and reg_rd may be high in a cycle.
// Fault events are levels on sys_clk and need no filtering.
// The alarm reset pin is asynchronous and filtered, so a clear through it
// lands about five clocks after the pin rises; short glitches are lost.
// The selector lock and power-cycle flags are header constants; with both
// clear the staged copy still brings the last written selector back after rst_b.
// Simultaneous faults resolve to the lowest event position.
// An unmapped or reserved address reads zero and refuses writes.
`timescale 1ns/1ps
`default_nettype none
`include "drive_alarm_status_regs.vh"

module drive_alarm_status_regs (
   input wire sys_clk,
   input wire rst_b,
   input wire por_b,
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   output reg reg_ack,
   output reg reg_refused,
   input wire servo_on,
   input wire [`FAULT_COUNT-1:0] fault_events,
   input wire alarm_reset_input,
   output reg [15:0] active_alarm_code,
   output wire alarm_active,
   output reg [15:0] panel_monitor_select
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   wire reset_level;
   wire [`FAULT_COUNT-1:0] gated_events;
   wire [15:0] new_code;
   wire new_fault;
   wire hit_version;
   wire hit_alarm;
   wire hit_select;
   wire hit_upper;
   wire hit_mapped;
   wire select_in_range;
   wire select_blocked;
   wire select_write_ok;
   wire alarm_clear_write;
   wire alarm_reset_edge;
   wire clear_req;
   reg wr_refused;
   reg reset_level_q;
   reg [15:0] select_shadow_q;
   reg [15:0] select_shadow_d;
   reg load_pending_q;
   reg [15:0] alarm_code_d;
   reg [15:0] select_d;
   reg [15:0] read_value;
   reg ack_d;
   reg refused_d;

   // ----------------------------------------
   // Alarm reset pin
   // ----------------------------------------
   // The reset function arrives from a pin in another domain, so it is filtered first.
   pin_sync3 u_reset_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin_in(alarm_reset_input),
      .level_q(reset_level)
   );

   // Only the rising edge of the filtered level acts; a held level does not
   // keep clearing alarms that arrive later.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_level_q <= 1'b0;
      end else begin
         reset_level_q <= reset_level;
      end
   end

   // The edge register resets low like the filtered level, so leaving reset
   // never looks like a press of the reset input.
   assign alarm_reset_edge = reset_level & ~reset_level_q;

   // ----------------------------------------
   // Fault event conditioning
   // ----------------------------------------
   // Under-voltage is masked while the servo is off in the default setting.
   // Nothing here looks at mains coming back, so the latched alarm stays.
   // The mask acts on the raw event only; a code already latched is kept
   // even when the servo is switched off afterwards.
   genvar g;
   generate
      for (g = 0; g < `FAULT_COUNT; g = g + 1) begin : g_gate
         if (g == `FAULT_UNDER_VOLTAGE_BIT) begin : g_uv
            assign gated_events[g] = fault_events[g] & (servo_on | ~`UV_ONLY_SERVO_ON);
         end else begin : g_plain
            assign gated_events[g] = fault_events[g];
         end
      end
   endgenerate

   // The encoder maps each event position to its BCD code.
   alarm_code_encoder u_encoder (
      .fault_vec(gated_events),
      .code(new_code),
      .any_fault(new_fault)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Each register owns an even address and the odd one above it.
   assign hit_version = (reg_addr == `ADDR_FIRMWARE_VERSION);
   assign hit_alarm = (reg_addr == `ADDR_ACTIVE_ALARM_CODE);
   assign hit_select = (reg_addr == `ADDR_PANEL_MONITOR_SELECT);
   assign hit_upper = reg_addr[0] & (reg_addr <= (`ADDR_PANEL_MONITOR_SELECT | 16'h0001));

   // Anything outside the three pairs is unmapped.
   assign hit_mapped = hit_version | hit_alarm | hit_select | hit_upper;

   // Selector values: 0 to 111, or the single negative value -112.
   assign select_in_range = (reg_wdata <= `MONITOR_SELECT_MAX) | (reg_wdata == `MONITOR_SELECT_NEG);

   // Selector lock while the servo runs, when the attribute is set.
   assign select_blocked = `SELECT_LOCKED_SERVO_ON & servo_on;

   // A selector write is stored only when legal and not locked.
   assign select_write_ok = reg_wr & hit_select & select_in_range & ~select_blocked;

   // Only the clear value is accepted by the alarm register.
   assign alarm_clear_write = reg_wr & hit_alarm & (reg_wdata == `ALARM_CLEAR_VALUE);

   assign clear_req = alarm_clear_write | alarm_reset_edge;

   // ----------------------------------------
   // Write refusal
   // ----------------------------------------
   // Each target is judged on its own so the refusal flag and the storage
   // enables cannot disagree: a write is either kept or refused.
   // Reads are never refused; an unmapped read simply returns zero.
   always @* begin
      wr_refused = 1'b0;
      if (reg_wr) begin
         if (!hit_mapped) begin
            wr_refused = 1'b1;
         end else if (hit_version) begin
            wr_refused = 1'b1;
         end else if (hit_alarm) begin
            wr_refused = (reg_wdata != `ALARM_CLEAR_VALUE);
         end else if (hit_select) begin
            wr_refused = ~select_in_range | select_blocked;
         end else begin
            wr_refused = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Active alarm latch
   // ----------------------------------------
   // The first fault is held until cleared, so the code seen is the cause and
   // not a later side effect. A fault present in the clearing cycle is taken,
   // so an event is never lost to a clear.
   always @* begin
      alarm_code_d = active_alarm_code;
      if (clear_req) begin
         if (new_fault) begin
            alarm_code_d = new_code;
         end else begin
            alarm_code_d = `ALARM_NONE;
         end
      end else if (active_alarm_code == `ALARM_NONE && new_fault) begin
         alarm_code_d = new_code;
      end
   end

   // ----------------------------------------
   // Alarm register
   // ----------------------------------------
   // Zero is the idle value after reset.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         active_alarm_code <= `ALARM_NONE;
      end else begin
         active_alarm_code <= alarm_code_d;
      end
   end

   // A code of zero means no alarm.
   assign alarm_active = (active_alarm_code != `ALARM_NONE);

   // ----------------------------------------
   // Monitor selector, staged and active
   // ----------------------------------------
   // The staged copy survives rst_b and is wiped only by por_b, which lets a
   // power-cycle attribute hold a written value across the restart.
   always @* begin
      select_shadow_d = select_shadow_q;
      if (select_write_ok) begin
         select_shadow_d = reg_wdata;
      end
   end

   always @(posedge sys_clk or negedge por_b) begin
      if (!por_b) begin
         select_shadow_q <= `MONITOR_SELECT_RESET;
      end else begin
         select_shadow_q <= select_shadow_d;
      end
   end

   // After each restart the active selector is reloaded once from the staged
   // copy; this is where a power-cycle value finally takes effect.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         load_pending_q <= 1'b1;
      end else begin
         load_pending_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Active selector
   // ----------------------------------------
   // The reload wins over a write in the same edge. A selector flagged for
   // power-cycle effect skips the direct update and waits for the reload.
   always @* begin
      select_d = panel_monitor_select;
      if (load_pending_q) begin
         select_d = select_shadow_q;
      end else if (select_write_ok && !`SELECT_POWER_CYCLE) begin
         select_d = reg_wdata;
      end
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         panel_monitor_select <= `MONITOR_SELECT_RESET;
      end else begin
         panel_monitor_select <= select_d;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Reserved upper words and unmapped addresses read as zero.
   always @* begin
      read_value = 16'h0000;
      if (hit_version) begin
         read_value = `FIRMWARE_VERSION_VALUE;
      end else if (hit_alarm) begin
         read_value = active_alarm_code;
      end else if (hit_select) begin
         read_value = panel_monitor_select;
      end else if (hit_upper) begin
         read_value = 16'h0000;
      end else begin
         read_value = 16'h0000;
      end
   end

   // ----------------------------------------
   // Answer registers
   // ----------------------------------------
   // Every access is answered one clock later; the data stays until the
   // next read so a slow link may sample it at leisure.
   always @* begin
      ack_d = reg_wr | reg_rd;
      refused_d = wr_refused;
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_ack <= 1'b0;
         reg_refused <= 1'b0;
      end else begin
         reg_ack <= ack_d;
         reg_refused <= refused_d;
      end
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Captured only on reads, so a write in between leaves the last answer
   // standing for a slow link to collect.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= read_value;
      end
   end

endmodule // drive_alarm_status_regs

`default_nettype wire

// *** verification/drive_alarm_status_regs_asserts.sv ***
// Checker for the drive alarm and monitor register bank.
`timescale 1ns/1ps
`default_nettype none
`include "drive_alarm_status_regs.vh"

module drive_alarm_status_regs_chk (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic por_b,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_refused,
   input wire logic servo_on,
   input wire logic [`FAULT_COUNT-1:0] fault_events,
   input wire logic alarm_reset_input,
   input wire logic [15:0] active_alarm_code,
   input wire logic alarm_active,
   input wire logic [15:0] panel_monitor_select
);
   // ----------------------------------------
   // Bus and alarm properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // Selector values the bank accepts.
   wire sel_ok = (reg_wdata <= `MONITOR_SELECT_MAX) || (reg_wdata == `MONITOR_SELECT_NEG);

   // An alarm read whose code does not move meanwhile, so the answer is unambiguous.
   sequence s_alarm_rd;
      reg_rd && reg_addr == `ADDR_ACTIVE_ALARM_CODE ##1 $stable(active_alarm_code);
   endsequence

   // A clear request while no fault is pending.
   sequence s_clear;
      reg_wr && reg_addr == `ADDR_ACTIVE_ALARM_CODE && reg_wdata == `ALARM_CLEAR_VALUE && fault_events == 0;
   endsequence

   AST_ACK: assert property (reg_ack == $past(reg_wr || reg_rd))
      else $error("ack does not follow request");
   AST_VER_RD: assert property (reg_rd && reg_addr == `ADDR_FIRMWARE_VERSION |=> reg_rdata == `FIRMWARE_VERSION_VALUE)
      else $error("version read wrong");
   AST_VER_WR: assert property (reg_wr && reg_addr == `ADDR_FIRMWARE_VERSION |=> reg_refused)
      else $error("version write not refused");
   AST_ALARM_RD: assert property (s_alarm_rd |-> reg_rdata == active_alarm_code)
      else $error("alarm read wrong");
   AST_NZ_WR: assert property (reg_wr && reg_addr == `ADDR_ACTIVE_ALARM_CODE && reg_wdata != 0 |=> reg_refused)
      else $error("nonzero alarm write accepted");
   AST_CLEAR: assert property (s_clear |=> active_alarm_code == `ALARM_NONE && !alarm_active)
      else $error("alarm not cleared");
   AST_SEL_OK: assert property (reg_wr && reg_addr == `ADDR_PANEL_MONITOR_SELECT && sel_ok
      |=> panel_monitor_select == $past(reg_wdata) && !reg_refused)
      else $error("selector write lost");
   AST_SEL_BAD: assert property (reg_wr && reg_addr == `ADDR_PANEL_MONITOR_SELECT && !sel_ok
      |=> reg_refused && $stable(panel_monitor_select))
      else $error("bad selector value taken");
   AST_ODD: assert property (reg_rd && reg_addr[0] |=> reg_rdata == 16'h0000)
      else $error("upper word not zero");
   AST_ACTIVE: assert property (alarm_active == (active_alarm_code != `ALARM_NONE))
      else $error("alarm flag disagrees with code");
   AST_FIRST: assert property (active_alarm_code == 0 && fault_events[0] |=> active_alarm_code == `CODE_OVER_CURRENT)
      else $error("over-current not latched");
   AST_UV: assert property (active_alarm_code == 0 && fault_events == 28'h0000004 && !servo_on
      |=> active_alarm_code == `ALARM_NONE)
      else $error("under-voltage raised with servo off");
endmodule // drive_alarm_status_regs_chk

bind drive_alarm_status_regs drive_alarm_status_regs_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .reg_refused(reg_refused), .servo_on(servo_on), .fault_events(fault_events),
   .alarm_reset_input(alarm_reset_input), .active_alarm_code(active_alarm_code), .alarm_active(alarm_active),
   .panel_monitor_select(panel_monitor_select));

`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking testbench for the drive alarm and monitor register bank.
`timescale 1ns/1ps
`default_nettype none
`include "drive_alarm_status_regs.vh"
`define CHECK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
   logic sys_clk = 0;
   logic rst_b = 0;
   logic por_b = 0;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic servo_on = 0;
   logic alarm_reset_input = 0;
   logic [15:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0;
   logic [27:0] fault_events = 0;
   logic [15:0] got;
   wire [15:0] reg_rdata;
   wire [15:0] active_alarm_code;
   wire [15:0] panel_monitor_select;
   wire reg_ack;
   wire reg_refused;
   wire alarm_active;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;

   drive_alarm_status_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_refused(reg_refused), .servo_on(servo_on), .fault_events(fault_events),
      .alarm_reset_input(alarm_reset_input), .active_alarm_code(active_alarm_code),
      .alarm_active(alarm_active), .panel_monitor_select(panel_monitor_select));

   // ----------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------
   always #2.5 sys_clk = ~sys_clk;

   // The whole run needs a few hundred cycles, so this ceiling only trips on a hang.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish;
      end
   end

   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask

   // Strobes stay up between accesses so back-to-back transfers never reassign them in one step.
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic xr);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      tick;
      got = reg_rdata;
      `CHECK(reg_ack, 1'b1)
      `CHECK(reg_refused, xr)
   endtask

   task automatic idle;
      reg_wr = 0;
      reg_rd = 0;
      tick;
   endtask

   // Expected BCD code of each fault position.
   function automatic logic [15:0] code_of(int i);
      int d;
      d = i < 9 ? i + 1 : i < 19 ? i + 2 : i < 25 ? i + 3 : i == 25 ? 30 : i == 26 ? 31 : 99;
      return 16'((d / 10) * 16 + d % 10);
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      acc(0, 16'h0000, 0, 0);
      `CHECK(got, `FIRMWARE_VERSION_VALUE)
      acc(1, 16'h0000, 16'h1234, 1);
      acc(0, 16'h0000, 0, 0);
      `CHECK(got, `FIRMWARE_VERSION_VALUE)
      acc(0, 16'h0002, 0, 0);
      `CHECK(got, 16'h0000)
      for (int a = 1; a < 6; a += 2) begin
         acc(0, 16'(a), 0, 0);
         `CHECK(got, 16'h0000)
         acc(1, 16'(a), 16'h0001, 1);
      end
      acc(1, 16'h0006, 16'h0000, 1);
      idle;
      $display("test regs done");
   endtask

   task automatic t_codes;
      servo_on = 1;
      for (int i = 0; i < 28; i++) begin
         fault_events = 28'(1) << i;
         tick;
         tick;
         `CHECK(active_alarm_code, code_of(i))
         `CHECK(alarm_active, 1'b1)
         acc(0, 16'h0002, 0, 0);
         `CHECK(got, code_of(i))
         fault_events = 0;
         acc(1, 16'h0002, 16'h0001, 1);
         `CHECK(active_alarm_code, code_of(i))
         acc(1, 16'h0002, 16'h0000, 0);
         idle;
         `CHECK(active_alarm_code, 16'h0000)
      end
      $display("test codes done");
   endtask

   task automatic t_uv;
      int k;
      servo_on = 0;
      fault_events = 28'h0000004;
      repeat (3) tick;
      `CHECK(active_alarm_code, 16'h0000)
      servo_on = 1;
      tick;
      tick;
      `CHECK(active_alarm_code, `CODE_UNDER_VOLTAGE)
      fault_events = 28'h0000001;
      tick;
      tick;
      `CHECK(active_alarm_code, `CODE_UNDER_VOLTAGE)
      fault_events = 0;
      alarm_reset_input = 1;
      for (k = 0; k < 20 && active_alarm_code !== 16'h0000; k++) tick;
      `CHECK(active_alarm_code, 16'h0000)
      alarm_reset_input = 0;
      repeat (8) tick;
      $display("test uv done");
   endtask

   task automatic t_sel;
      logic [15:0] v [6] = '{16'h0000, 16'h006f, 16'hff90, 16'h0070, 16'hff8f, 16'h8000};
      servo_on = 1;
      for (int i = 0; i < 6; i++) begin
         acc(1, 16'h0004, v[i], i > 2);
         acc(0, 16'h0004, 0, 0);
         `CHECK(got, (i > 2) ? v[2] : v[i])
         `CHECK(panel_monitor_select, (i > 2) ? v[2] : v[i])
      end
      idle;
      $display("test sel done");
   endtask

   task automatic t_pwr;
      acc(1, 16'h0004, 16'h0005, 0);
      idle;
      rst_b = 0;
      tick;
      `CHECK(panel_monitor_select, 16'h0000)
      rst_b = 1;
      tick;
      tick;
      `CHECK(panel_monitor_select, 16'h0005)
      rst_b = 0;
      por_b = 0;
      tick;
      rst_b = 1;
      por_b = 1;
      tick;
      tick;
      `CHECK(panel_monitor_select, 16'h0000)
      $display("test pwr done");
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Reset is held ten cycles, then the first request waits out the reload edge.
   initial begin
      repeat (10) tick;
      rst_b = 1;
      por_b = 1;
      tick;
      t_regs;
      t_codes;
      t_uv;
      t_sel;
      t_pwr;
      tally_and_finish;
   end
endmodule // tb_top

`default_nettype wire
